// ---- core/hpd_pkg.sv ----
// processor-side host port constants: word offsets, bit positions, reset values
// assumes a processor bus that selects one of three words with a two-bit address
package hpd_pkg;
   localparam int         DATA_W       = 24;
   localparam int         REG_W        = 8;
   localparam int         SYNC_W       = 8;
   // word offsets seen by the processor
   localparam logic [1:0] ADDR_CONTROL = 2'h0;
   localparam logic [1:0] ADDR_STATUS  = 2'h1;
   localparam logic [1:0] ADDR_DATA    = 2'h2;
   // control bit positions
   localparam int         CTL_RX_IE    = 0;
   localparam int         CTL_TX_IE    = 1;
   localparam int         CTL_CMD_IE   = 2;
   localparam int         CTL_FLAG_A   = 3;
   localparam int         CTL_FLAG_B   = 4;
   localparam logic [7:0] CTL_WR_MASK  = 8'h1F;
   // status bit positions
   localparam int         STS_RX_FULL  = 0;
   localparam int         STS_TX_EMPTY = 1;
   localparam int         STS_CMD_PEND = 2;
   localparam int         STS_FLAG_A   = 3;
   localparam int         STS_FLAG_B   = 4;
   localparam int         STS_DMA      = 7;
   // synchroniser lane positions
   localparam int         SY_TX_EMPTY  = 0;
   localparam int         SY_RX_FULL   = 1;
   localparam int         SY_CMD_REQ   = 2;
   localparam int         SY_FLAG_A    = 3;
   localparam int         SY_FLAG_B    = 4;
   localparam int         SY_DMA_A     = 5;
   localparam int         SY_DMA_B     = 6;
   localparam int         SY_INIT_TGL  = 7;
   // reset values and buffer depth
   localparam logic [7:0] CONTROL_RST  = 8'h00;
   localparam logic       TX_EMPTY_RST = 1'b1;
   localparam logic       RX_FULL_RST  = 1'b0;
   localparam logic [1:0] BUF_DEPTH    = 2'h2;
endpackage

// ---- core/hpd_pair_buffer.sv ----
// two-entry buffer with valid/ready on both sides; head word comes from a register
// assumes producer and consumer share mclk
`timescale 1ns/1ps
module hpd_pair_buffer (
   input  wire logic                        mclk,     // clock
   input  wire logic                        rst,      // sync reset
   input  wire logic                        clr,      // flush
   input  wire logic [hpd_pkg::DATA_W-1:0]  inData,   // word in
   input  wire logic                        inValid,  // word offered
   output logic                             inReady,  // room for a word
   output logic      [hpd_pkg::DATA_W-1:0]  outData,  // head word
   output logic                             outValid, // head valid
   input  wire logic                        outReady  // consumer takes head
);
   logic [hpd_pkg::DATA_W-1:0] head_reg, head_next;
   logic [hpd_pkg::DATA_W-1:0] tail_reg, tail_next;
   logic [1:0]                 count_reg, count_next;
   logic                       push, pop;

   assign inReady  = (count_reg != hpd_pkg::BUF_DEPTH);
   assign outValid = (count_reg != 2'h0);
   assign outData  = head_reg;
   assign push     = inValid && inReady;
   assign pop      = outValid && outReady;

   always_comb
   begin
      head_next  = head_reg;
      tail_next  = tail_reg;
      count_next = count_reg;
      if (clr)
      begin
         count_next = 2'h0;
      end
      else
      begin
         if (pop)
         begin
            head_next = tail_reg;
         end
         if (push)
         begin
            if (count_reg == 2'h0 || (count_reg == 2'h1 && pop))
               head_next = inData;
            else
               tail_next = inData;
         end
         count_next = count_reg + {1'b0, push} - {1'b0, pop};
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         head_reg  <= 24'h00_0000;
         tail_reg  <= 24'h00_0000;
         count_reg <= 2'h0;
      end
      else
      begin
         head_reg  <= head_next;
         tail_reg  <= tail_next;
         count_reg <= count_next;
      end
   end

   chk_buf_no_overflow : assert property (@(posedge mclk) disable iff (rst)
      count_reg <= hpd_pkg::BUF_DEPTH)
      else $error("pair buffer count above depth");
endmodule

// ---- core/hpd_dsp_port.sv ----
// processor-side control, status and data word logic of the byte-wide host port
// assumes host-side levels are asynchronous and held stable; host data stable while its empty flag is low
//
// Behaviour
// R1 - control register is eight bits, processor read/write, low byte, upper bits zero
// R2 - control bits 5 to 7 read zero; software writes zeros there
// R3 - hardware and software reset clear the whole control register
// R4 - receive interrupt requested while its enable and receive-word-full are set
// R5 - transmit interrupt requested while its enable and transmit-word-empty are set
// R6 - command interrupt requested while enabled and command pending; host supplies vector
// R7 - control bits 3 and 4 are flags shown to host; resets clear them; here only hardware and software reset clear them
// R8 - the four general flags never raise any interrupt
// R9 - status register is eight bits, read-only, low byte, upper bits zero
// R10 - receive-word-full set on host bytes move, cleared by reading the word
// R11 - receive-word-full also cleared by host initialize and all four resets
// R12 - transmit-word-empty set on move to host, cleared by writing the word
// R13 - transmit-word-empty also set by host initialize and all four resets
// R14 - command pending mirrors host command request; all resets clear it
// R15 - taking the command exception clears request and pending
// R16 - status bits 3 and 4 show host flags; all resets clear them
// R17 - status bits 5 and 6 read zero
// R18 - status bit 7 set while either host DMA mode bit is set
// R19 - hardware and software reset disable the port, pins become inputs
// R20 - processor sees control, status and shared data words, data 24 bits
// R21 - host addresses eight byte locations and combines bytes into words
// R22 - host bytes load receive word only when host empty and full both clear
// R23 - transmit word moves to host only when empty and host full both clear
// R24 - each host-driven status level synchronised separately into mclk
// R25 - each interrupt request is the level AND of enable and status
`timescale 1ns/1ps
module hpd_dsp_port (
   input  wire logic        mclk,             // 200 MHz clock
   input  wire logic        rst,              // hardware reset, sync, high
   input  wire logic        swReset,          // software reset pulse
   input  wire logic        stopReset,        // stop reset pulse
   input  wire logic        portSelect,       // port B host function selected, low is individual reset
   input  wire logic        cpuSel,           // processor access strobe
   input  wire logic        cpuWr,            // 1 write, 0 read
   input  wire logic [1:0]  cpuAddr,          // word select
   input  wire logic [23:0] cpuWdata,         // write data
   output logic      [23:0] cpuRdata,         // read data, one cycle after strobe
   input  wire logic        cmdExcTaken,      // command exception taken pulse
   output logic             rxIrq,            // receive data interrupt level
   output logic             txIrq,            // transmit data interrupt level
   output logic             cmdIrq,           // command interrupt level
   output logic      [6:0]  cmdVectorOut,     // service vector for command interrupt
   output logic             portEnable,       // host function active, else pins are inputs
   input  wire logic        hostTxEmpty,      // host transmit bytes empty (async)
   input  wire logic        hostRxFull,       // host receive bytes full (async)
   input  wire logic        commandRequest,   // host command request (async)
   input  wire logic [6:0]  commandVector,    // host command vector (async, stable with request)
   input  wire logic        hostFlagA,        // host-to-processor flag a (async)
   input  wire logic        hostFlagB,        // host-to-processor flag b (async)
   input  wire logic        hostDmaModeA,     // host dma mode a (async)
   input  wire logic        hostDmaModeB,     // host dma mode b (async)
   input  wire logic        hostInitToggle,   // toggles once per host initialize
   input  wire logic [23:0] hostTxBytes,      // host transmit bytes (async)
   output logic             hostTxTaken,      // pulse: host bytes taken, host sets its empty flag
   output logic      [23:0] hostRxBytes,      // word for host receive bytes
   output logic             hostRxLoad,       // pulse: host loads receive bytes, sets its full flag
   output logic             cmdClear,         // pulse: host clears its command request
   output logic             dspFlagA,         // processor-to-host flag a
   output logic             dspFlagB          // processor-to-host flag b
);
   logic [7:0]  sync1_reg, sync2_reg, sync3_reg;
   logic [23:0] dataS1_reg, dataS2_reg;
   logic [6:0]  vecS1_reg, vecS2_reg;
   logic [7:0]  dsp_control_reg, control_next;
   logic        rxWordFull_reg, rxWordFull_next;
   logic        txWordEmpty_reg, txWordEmpty_next;
   logic        rxWait_reg, rxWait_next;
   logic        txWait_reg, txWait_next;
   logic        cmdHold_reg, cmdHold_next;
   logic [23:0] dspRxWord_reg, dspRxWord_next;
   logic [23:0] dspTxWord_reg, dspTxWord_next;
   logic [23:0] cpuRdata_reg, cpuRdata_next;
   logic        rxIrq_reg, txIrq_reg, cmdIrq_reg;
   logic [6:0]  cmdVector_reg;
   logic        portEnable_reg, portEnable_next;
   logic        hostTxTaken_reg, hostTxTaken_next;
   logic        hostRxLoad_reg, hostRxLoad_next;
   logic [23:0] hostRxBytes_reg, hostRxBytes_next;
   logic        cmdClear_reg, cmdClear_next;
   logic [7:0]  dsp_status_reg;
   logic        fullClr, statusClr, hostInit, commandPending;
   logic        cpuWrCtl, cpuWrData, cpuRdData, rxMove, txMove;
   logic        bufInReady, bufOutValid, bufOutReady;
   logic [23:0] bufOutData;

   // two-flop synchronisers; third stage feeds the init edge detect
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         sync1_reg  <= 8'h00;
         sync2_reg  <= 8'h00;
         sync3_reg  <= 8'h00;
         dataS1_reg <= 24'h00_0000;
         dataS2_reg <= 24'h00_0000;
         vecS1_reg  <= 7'h00;
         vecS2_reg  <= 7'h00;
      end
      else
      begin
         sync1_reg  <= {hostInitToggle, hostDmaModeB, hostDmaModeA, hostFlagB, hostFlagA,
                        commandRequest, hostRxFull, hostTxEmpty}; // see R24
         sync2_reg  <= sync1_reg;
         sync3_reg  <= sync2_reg;
         dataS1_reg <= hostTxBytes;
         dataS2_reg <= dataS1_reg;
         vecS1_reg  <= commandVector;
         vecS2_reg  <= vecS1_reg;
      end
   end

   assign fullClr   = rst || swReset;
   assign statusClr = fullClr || stopReset || !portSelect;
   assign hostInit  = sync2_reg[hpd_pkg::SY_INIT_TGL] ^ sync3_reg[hpd_pkg::SY_INIT_TGL];
   assign cpuWrCtl  = cpuSel && cpuWr && (cpuAddr == hpd_pkg::ADDR_CONTROL);
   assign cpuWrData = cpuSel && cpuWr && (cpuAddr == hpd_pkg::ADDR_DATA);
   assign cpuRdData = cpuSel && !cpuWr && (cpuAddr == hpd_pkg::ADDR_DATA);
   // pending drops once the exception is taken
   assign commandPending = sync2_reg[hpd_pkg::SY_CMD_REQ] && !cmdHold_reg && !statusClr; // see R14
   // host word moves only with both flags clear
   assign rxMove = !sync2_reg[hpd_pkg::SY_TX_EMPTY] && !rxWordFull_reg && !rxWait_reg && !statusClr; // see R22
   // transmit word enters the buffer only with both flags clear
   assign txMove = !txWordEmpty_reg && !sync2_reg[hpd_pkg::SY_RX_FULL] && bufInReady && !statusClr; // see R23
   // buffer releases once host full is seen clear
   assign bufOutReady = !sync2_reg[hpd_pkg::SY_RX_FULL] && !txWait_reg && !hostRxLoad_reg;

   always_comb
   begin
      dsp_status_reg = 8'h00; // see R17
      dsp_status_reg[hpd_pkg::STS_RX_FULL]  = rxWordFull_reg;
      dsp_status_reg[hpd_pkg::STS_TX_EMPTY] = txWordEmpty_reg;
      dsp_status_reg[hpd_pkg::STS_CMD_PEND] = commandPending;
      dsp_status_reg[hpd_pkg::STS_FLAG_A]   = sync2_reg[hpd_pkg::SY_FLAG_A] && !statusClr; // see R16
      dsp_status_reg[hpd_pkg::STS_FLAG_B]   = sync2_reg[hpd_pkg::SY_FLAG_B] && !statusClr;
      dsp_status_reg[hpd_pkg::STS_DMA]      = (sync2_reg[hpd_pkg::SY_DMA_A] || sync2_reg[hpd_pkg::SY_DMA_B])
                                              && !statusClr; // see R18
   end

   always_comb
   begin
      control_next     = dsp_control_reg;
      rxWordFull_next  = rxWordFull_reg;
      txWordEmpty_next = txWordEmpty_reg;
      rxWait_next      = rxWait_reg;
      txWait_next      = txWait_reg;
      cmdHold_next     = cmdHold_reg;
      dspRxWord_next   = dspRxWord_reg;
      dspTxWord_next   = dspTxWord_reg;
      cpuRdata_next    = 24'h00_0000;
      hostTxTaken_next = 1'b0;
      hostRxLoad_next  = 1'b0;
      hostRxBytes_next = hostRxBytes_reg;
      cmdClear_next    = 1'b0;
      portEnable_next  = portSelect;
      // processor reads, low byte only for control and status
      if (cpuSel && !cpuWr)
      begin
         if (cpuAddr == hpd_pkg::ADDR_CONTROL)
            cpuRdata_next = {16'h0000, dsp_control_reg}; // see R1
         else if (cpuAddr == hpd_pkg::ADDR_STATUS)
            cpuRdata_next = {16'h0000, dsp_status_reg}; // see R9
         else if (cpuAddr == hpd_pkg::ADDR_DATA)
            cpuRdata_next = dspRxWord_reg; // see R20
         else
            cpuRdata_next = 24'h00_0000;
      end
      if (cpuWrCtl)
      begin
         control_next = cpuWdata[7:0] & hpd_pkg::CTL_WR_MASK; // see R2 R7
      end
      // receive path
      if (cpuRdData)
      begin
         rxWordFull_next = 1'b0; // see R10
      end
      if (rxMove)
      begin
         dspRxWord_next   = dataS2_reg;
         rxWordFull_next  = 1'b1; // see R10 R22
         hostTxTaken_next = 1'b1;
         rxWait_next      = 1'b1;
      end
      if (rxWait_reg && sync2_reg[hpd_pkg::SY_TX_EMPTY])
      begin
         rxWait_next = 1'b0;
      end
      // transmit path
      if (cpuWrData)
      begin
         dspTxWord_next   = cpuWdata;
         txWordEmpty_next = 1'b0; // see R12
      end
      if (txMove)
      begin
         txWordEmpty_next = 1'b1; // see R12 R23
      end
      if (bufOutValid && bufOutReady)
      begin
         hostRxBytes_next = bufOutData;
         hostRxLoad_next  = 1'b1;
         txWait_next      = 1'b1;
      end
      if (txWait_reg && sync2_reg[hpd_pkg::SY_RX_FULL])
      begin
         txWait_next = 1'b0;
      end
      // command exception clears the host request and holds pending low until it falls
      if (cmdExcTaken && commandPending)
      begin
         cmdHold_next  = 1'b1; // see R15
         cmdClear_next = 1'b1;
      end
      else if (cmdHold_reg && !sync2_reg[hpd_pkg::SY_CMD_REQ])
      begin
         cmdHold_next = 1'b0;
      end
      // host initialize: set wins over a same-cycle processor write
      if (hostInit)
      begin
         rxWordFull_next  = rxMove; // see R11
         txWordEmpty_next = 1'b1; // see R13
      end
      if (statusClr)
      begin
         rxWordFull_next  = hpd_pkg::RX_FULL_RST; // see R11
         txWordEmpty_next = hpd_pkg::TX_EMPTY_RST; // see R13
         rxWait_next      = 1'b0;
         txWait_next      = 1'b0;
         cmdHold_next     = 1'b0;
      end
      if (fullClr)
      begin
         control_next    = hpd_pkg::CONTROL_RST; // see R3 R7
         portEnable_next = 1'b0; // see R19
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         dsp_control_reg <= hpd_pkg::CONTROL_RST;
         rxWordFull_reg  <= hpd_pkg::RX_FULL_RST;
         txWordEmpty_reg <= hpd_pkg::TX_EMPTY_RST;
         rxWait_reg      <= 1'b1;
         txWait_reg      <= 1'b0;
         cmdHold_reg     <= 1'b0;
         dspRxWord_reg   <= 24'h00_0000;
         dspTxWord_reg   <= 24'h00_0000;
         cpuRdata_reg    <= 24'h00_0000;
         hostTxTaken_reg <= 1'b0;
         hostRxLoad_reg  <= 1'b0;
         hostRxBytes_reg <= 24'h00_0000;
         cmdClear_reg    <= 1'b0;
         portEnable_reg  <= 1'b0;
         rxIrq_reg       <= 1'b0;
         txIrq_reg       <= 1'b0;
         cmdIrq_reg      <= 1'b0;
         cmdVector_reg   <= 7'h00;
      end
      else
      begin
         dsp_control_reg <= control_next;
         rxWordFull_reg  <= rxWordFull_next;
         txWordEmpty_reg <= txWordEmpty_next;
         rxWait_reg      <= rxWait_next;
         txWait_reg      <= txWait_next;
         cmdHold_reg     <= cmdHold_next;
         dspRxWord_reg   <= dspRxWord_next;
         dspTxWord_reg   <= dspTxWord_next;
         cpuRdata_reg    <= cpuRdata_next;
         hostTxTaken_reg <= hostTxTaken_next;
         hostRxLoad_reg  <= hostRxLoad_next;
         hostRxBytes_reg <= hostRxBytes_next;
         cmdClear_reg    <= cmdClear_next;
         portEnable_reg  <= portEnable_next;
         // flags feed no request term
         rxIrq_reg       <= dsp_control_reg[hpd_pkg::CTL_RX_IE] && rxWordFull_reg; // see R4 R8 R25
         txIrq_reg       <= dsp_control_reg[hpd_pkg::CTL_TX_IE] && txWordEmpty_reg; // see R5 R25
         cmdIrq_reg      <= dsp_control_reg[hpd_pkg::CTL_CMD_IE] && commandPending; // see R6 R25
         cmdVector_reg   <= vecS2_reg; // see R6
      end
   end

   hpd_pair_buffer u_txBuf (
      .mclk     (mclk),
      .rst      (rst),
      .clr      (statusClr),
      .inData   (dspTxWord_reg),
      .inValid  (txMove),
      .inReady  (bufInReady),
      .outData  (bufOutData),
      .outValid (bufOutValid),
      .outReady (bufOutReady)
   );

   assign cpuRdata     = cpuRdata_reg;
   assign rxIrq        = rxIrq_reg;
   assign txIrq        = txIrq_reg;
   assign cmdIrq       = cmdIrq_reg;
   assign cmdVectorOut = cmdVector_reg;
   assign portEnable   = portEnable_reg;
   assign hostTxTaken  = hostTxTaken_reg;
   assign hostRxBytes  = hostRxBytes_reg;
   assign hostRxLoad   = hostRxLoad_reg;
   assign cmdClear     = cmdClear_reg;
   assign dspFlagA     = dsp_control_reg[hpd_pkg::CTL_FLAG_A];
   assign dspFlagB     = dsp_control_reg[hpd_pkg::CTL_FLAG_B];

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   sequence s_sw_reset;
      swReset;
   endsequence
   sequence s_rx_read;
      cpuRdData && !rxMove && !statusClr;
   endsequence

   chk_ctrl_cleared  : assert property (s_sw_reset |=> dsp_control_reg == 8'h00 && !portEnable) // see R3 R19
      else $error("control not cleared by software reset");
   chk_ctrl_resv     : assert property (dsp_control_reg[7:5] == 3'h0) // see R2
      else $error("reserved control bits set");
   chk_rx_read_clr   : assert property (s_rx_read |=> !rxWordFull_reg) // see R10
      else $error("reading receive word did not clear full");
   chk_rx_move       : assert property (rxMove |=> rxWordFull_reg && hostTxTaken // see R22
      && dspRxWord_reg == $past(dataS2_reg))
      else $error("host word move failed");
   chk_tx_write_clr  : assert property (cpuWrData && !hostInit && !statusClr |=> !txWordEmpty_reg) // see R12
      else $error("writing transmit word left it empty");
   chk_reset_status  : assert property (stopReset |=> txWordEmpty_reg && !rxWordFull_reg) // see R11 R13
      else $error("stop reset did not restore status");
   chk_rx_irq_level  : assert property (rxIrq == $past(dsp_control_reg[0] && rxWordFull_reg)) // see R4 R25
      else $error("receive interrupt level wrong");
   chk_tx_irq_level  : assert property (txIrq == $past(dsp_control_reg[1] && txWordEmpty_reg)) // see R5
      else $error("transmit interrupt level wrong");
   chk_cmd_exc_clr   : assert property (cmdExcTaken && commandPending |=> !commandPending && cmdClear // see R15 R6
      ##1 !cmdIrq)
      else $error("command exception did not clear pending");
   chk_status_bits   : assert property (cpuSel && !cpuWr && cpuAddr == 2'h1 |=> cpuRdata[23:8] == 16'h0000
      && cpuRdata[6:5] == 2'h0 && cpuRdata[7] == $past(dsp_status_reg[7])) // see R9 R17 R18
      else $error("status read shape wrong");
endmodule

// ---- verif/hpd_host_model.sv ----
// host-side stand-in: transmit/receive bytes, their flags and the command request
// assumes the bench pulses push, drain and cmdSet for one mclk cycle
`timescale 1ns/1ps
module hpd_host_model (
   input  wire logic        mclk,           // clock
   input  wire logic        rst,            // reset
   input  wire logic        push,           // host writes a word
   input  wire logic [23:0] pushWord,       // word written
   input  wire logic        drain,          // host reads its bytes
   input  wire logic        cmdSet,         // host raises request
   input  wire logic        hostTxTaken,    // device took bytes
   input  wire logic        hostRxLoad,     // device loads bytes
   input  wire logic [23:0] hostRxBytes,    // word from device
   input  wire logic        cmdClear,       // device clears request
   output logic             hostTxEmpty,    // transmit bytes empty
   output logic             hostRxFull,     // receive bytes full
   output logic             commandRequest, // command request
   output logic      [23:0] hostTxBytes,    // transmit bytes
   output logic      [23:0] rxHold          // bytes as host reads them
);
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         hostTxEmpty <= 1'b1;
         hostRxFull <= 1'b0;
         commandRequest <= 1'b0;
         hostTxBytes <= 24'h00_0000;
      end
      else
      begin
         if (push)
         begin
            hostTxEmpty <= 1'b0;
            hostTxBytes <= pushWord;
         end
         else if (hostTxTaken)
         begin
            hostTxEmpty <= 1'b1;
            hostTxBytes <= ~hostTxBytes; // released bytes go stale
         end
         if (hostRxLoad)
            rxHold <= hostRxBytes;
         if (hostRxLoad)
            hostRxFull <= 1'b1;
         else if (drain)
            hostRxFull <= 1'b0;
         if (cmdSet)
            commandRequest <= 1'b1;
         else if (cmdClear)
            commandRequest <= 1'b0;
      end
   end
endmodule

// ---- verif/tb.sv ----
// self-checking bench for the processor side of the host port
// assumes the host model answers every load and take
`timescale 1ns/1ps
module tb;
   logic        mclk, rst, swReset, stopReset, portSelect, cpuSel, cpuWr, cmdExcTaken, push, drain, cmdSet, initTgl;
   logic        rxIrq, txIrq, cmdIrq, portEnable, hostTxTaken, hostRxLoad, cmdClear, dspFlagA, dspFlagB;
   logic        hostTxEmpty, hostRxFull, commandRequest, hostFlagA, hostFlagB, hostDmaModeA, hostDmaModeB;
   logic [1:0]  cpuAddr;
   logic [6:0]  commandVector, cmdVectorOut;
   logic [23:0] cpuWdata, cpuRdata, hostTxBytes, hostRxBytes, pushWord, rxHold, rd, w;
   int          miscompares, checks_done, seed, i, n;
   logic [23:0] expQ[$];
   hpd_dsp_port u_dut (.mclk(mclk), .rst(rst), .swReset(swReset), .stopReset(stopReset), .portSelect(portSelect),
      .cpuSel(cpuSel), .cpuWr(cpuWr), .cpuAddr(cpuAddr), .cpuWdata(cpuWdata), .cpuRdata(cpuRdata),
      .cmdExcTaken(cmdExcTaken), .rxIrq(rxIrq), .txIrq(txIrq), .cmdIrq(cmdIrq), .cmdVectorOut(cmdVectorOut),
      .portEnable(portEnable), .hostTxEmpty(hostTxEmpty), .hostRxFull(hostRxFull), .commandRequest(commandRequest),
      .commandVector(commandVector), .hostFlagA(hostFlagA), .hostFlagB(hostFlagB), .hostDmaModeA(hostDmaModeA),
      .hostDmaModeB(hostDmaModeB), .hostInitToggle(initTgl), .hostTxBytes(hostTxBytes), .hostTxTaken(hostTxTaken),
      .hostRxBytes(hostRxBytes), .hostRxLoad(hostRxLoad), .cmdClear(cmdClear), .dspFlagA(dspFlagA), .dspFlagB(dspFlagB));
   hpd_host_model u_host (.mclk(mclk), .rst(rst), .push(push), .pushWord(pushWord), .drain(drain), .cmdSet(cmdSet),
      .hostTxTaken(hostTxTaken), .hostRxLoad(hostRxLoad), .hostRxBytes(hostRxBytes), .cmdClear(cmdClear),
      .hostTxEmpty(hostTxEmpty), .hostRxFull(hostRxFull), .commandRequest(commandRequest),
      .hostTxBytes(hostTxBytes), .rxHold(rxHold));
   task automatic check(input logic [25:0] got, input logic [25:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cpu(input logic wr, input logic [1:0] a, input logic [23:0] d);
      @(negedge mclk);
      {cpuSel, cpuWr, cpuAddr, cpuWdata} = {1'b1, wr, a, d};
      @(negedge mclk);
      cpuSel = 1'b0;
      rd = cpuRdata;
   endtask
   task automatic hostSend(input logic [23:0] d);
      @(negedge mclk);
      {push, pushWord} = {1'b1, d};
      @(negedge mclk);
      push = 1'b0;
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial
   begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   initial
   begin
      #100000;
      miscompares++;
      print_verdict();
   end
   initial
   begin
      {seed, miscompares, checks_done, rst} = {32'd70, 64'd0, 1'b1};
      {swReset, stopReset, portSelect, cpuSel, cpuWr, cmdExcTaken, push, drain, cmdSet, initTgl} = '0;
      {hostFlagA, hostFlagB, hostDmaModeA, hostDmaModeB, cpuAddr, cpuWdata, commandVector, pushWord} = '0;
      repeat (3) @(negedge mclk);
      rst = 1'b0;
      cpu(0, hpd_pkg::ADDR_CONTROL, 0);
      check(rd, 0);
      cpu(0, hpd_pkg::ADDR_STATUS, 0);
      check(rd, 24'h00_0002);
      check(portEnable, 0);
      portSelect = 1'b1;
      for (i = 0; i < 6; i++)
      begin
         w = (i == 0) ? 24'h00_00FF : $random(seed);
         cpu(1, hpd_pkg::ADDR_CONTROL, w);
         cpu(0, hpd_pkg::ADDR_CONTROL, 0);
         check(rd, w & 24'h00_001F);
         check({dspFlagB, dspFlagA}, w[4:3]);
         check({cmdIrq, txIrq, rxIrq}, {1'b0, w[1], 1'b0});
      end
      for (i = 0; i < 6; i++)
      begin
         {hostDmaModeB, hostDmaModeA, hostFlagB, hostFlagA} = 4'($random(seed));
         repeat (4) @(negedge mclk);
         cpu(0, hpd_pkg::ADDR_STATUS, 0);
         check(rd, {hostDmaModeA | hostDmaModeB, 2'b00, hostFlagB, hostFlagA, 3'b010});
      end
      {hostDmaModeB, hostDmaModeA, hostFlagB, hostFlagA} = '0;
      cpu(1, hpd_pkg::ADDR_CONTROL, 24'h00_0001);
      for (i = 0; i < 2; i++)
      begin
         w = $random(seed);
         expQ.push_back(w);
         hostSend(w);
         for (n = 0; n < 40 && hostTxEmpty !== 1'b1 && i == 0; n++) @(negedge mclk);
      end
      repeat (10) @(negedge mclk);
      check(hostTxEmpty, 0);
      check(rxIrq, 1);
      cpu(0, hpd_pkg::ADDR_DATA, 0);
      check(rd, expQ.pop_front());
      for (n = 0; n < 40 && hostTxEmpty !== 1'b1; n++) @(negedge mclk);
      repeat (3) @(negedge mclk);
      cpu(0, hpd_pkg::ADDR_DATA, 0);
      check(rd, expQ.pop_front());
      repeat (3) @(negedge mclk);
      cpu(0, hpd_pkg::ADDR_STATUS, 0);
      check(rd, 24'h00_0002);
      check(rxIrq, 0);
      cpu(1, hpd_pkg::ADDR_CONTROL, 24'h00_0002);
      for (i = 0; i < 12; i++)
      begin
         cpu(0, hpd_pkg::ADDR_STATUS, 0);
         if (rd[1])
         begin
            w = $random(seed);
            expQ.push_back(w);
            cpu(1, hpd_pkg::ADDR_DATA, w);
         end
      end
      check(rd[1], 0);
      check(txIrq, 0);
      for (i = 0; i < 8 && expQ.size() > 0; i++)
      begin
         for (n = 0; n < 40 && hostRxFull !== 1'b1; n++) @(negedge mclk);
         check(rxHold, expQ.pop_front());
         drain = 1'b1;
         @(negedge mclk);
         drain = 1'b0;
      end
      repeat (6) @(negedge mclk);
      cpu(0, hpd_pkg::ADDR_STATUS, 0);
      check({rd[1], txIrq}, 2'b11);
      cpu(1, hpd_pkg::ADDR_CONTROL, 24'h00_0004);
      commandVector = 7'($random(seed));
      cmdSet = 1'b1;
      @(negedge mclk);
      cmdSet = 1'b0;
      for (n = 0; n < 40 && cmdIrq !== 1'b1; n++) @(negedge mclk);
      check({cmdIrq, cmdVectorOut}, {1'b1, commandVector});
      cpu(0, hpd_pkg::ADDR_STATUS, 0);
      check(rd[2], 1);
      cmdExcTaken = 1'b1;
      @(negedge mclk);
      cmdExcTaken = 1'b0;
      repeat (4) @(negedge mclk);
      cpu(0, hpd_pkg::ADDR_STATUS, 0);
      check({rd[2], commandRequest, cmdIrq}, 0);
      cpu(1, hpd_pkg::ADDR_CONTROL, 24'h00_001F);
      hostSend($random(seed));
      repeat (8) @(negedge mclk);
      initTgl = 1'b1;
      hostSend($random(seed));
      repeat (8) @(negedge mclk);
      check(hostTxEmpty, 1);
      stopReset = 1'b1;
      @(negedge mclk);
      stopReset = 1'b0;
      cpu(0, hpd_pkg::ADDR_STATUS, 0);
      check(rd, 24'h00_0002);
      cpu(0, hpd_pkg::ADDR_CONTROL, 0);
      check(rd, 24'h00_001F);
      {swReset, portSelect} = 2'b10;
      @(negedge mclk);
      swReset = 1'b0;
      cpu(0, hpd_pkg::ADDR_CONTROL, 0);
      check({rd, portEnable, dspFlagA}, 0);
      print_verdict();
   end
endmodule
